// file: hdl/ahbm_pkg.sv
// Constants and types for the bus master that drives pipelined transfers
// How it works
// R1 - Master holds address one cycle unless stalled
// R2 - Slave may stretch data phase with waits
// R3 - Address driven after edge, sampled next edge
// R4 - Zero-wait response sampled on third edge
// R5 - Address phase overlaps previous data phase
// R6 - Write data held stable through waits
// R7 - Read data valid only at completion
// R8 - Next address held while data phase stretched
// R9 - Transfer type 00 means IDLE
// R10 - Master with nothing to send shows IDLE
// R11 - Slave ignores IDLE, zero-wait OKAY
// R12 - BUSY pauses burst, shows next beat
// R13 - Slave answers BUSY like IDLE
// R14 - NONSEQ starts burst or single transfer
// R15 - Single transfer labelled NONSEQ
// R16 - SEQ keeps control, address plus size
// R17 - Wrapping burst wraps at size times beats
// R18 - Ready low inserts wait state
// R19 - Slave reports OKAY, ERROR, RETRY, SPLIT
// R20 - Slave captures address only when ready
// R21 - Master drives IDLE after reset
package ahbm_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int SIZE_W = 3;
  localparam int BURST_W = 3;
  localparam int LEN_W = 8;

  localparam logic [1:0] TR_IDLE = 2'h0;
  localparam logic [1:0] TR_BUSY = 2'h1;
  localparam logic [1:0] TR_NONSEQ = 2'h2;
  localparam logic [1:0] TR_SEQ = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_ERROR = 2'h1;
  localparam logic [1:0] RESP_RETRY = 2'h2;
  localparam logic [1:0] RESP_SPLIT = 2'h3;

  localparam logic [2:0] BURST_SINGLE = 3'h0;
  localparam logic [2:0] BURST_INCR = 3'h1;
  localparam logic [2:0] BURST_WRAP4 = 3'h2;
  localparam logic [2:0] BURST_INCR4 = 3'h3;
  localparam logic [2:0] BURST_WRAP8 = 3'h4;
  localparam logic [2:0] BURST_INCR8 = 3'h5;
  localparam logic [2:0] BURST_WRAP16 = 3'h6;
  localparam logic [2:0] BURST_INCR16 = 3'h7;

  localparam logic [LEN_W:0] BEATS_1 = 9'h001;
  localparam logic [LEN_W:0] BEATS_4 = 9'h004;
  localparam logic [LEN_W:0] BEATS_8 = 9'h008;
  localparam logic [LEN_W:0] BEATS_16 = 9'h010;

  typedef enum logic {AHBM_IDLE_S, AHBM_RUN_S} ahbm_state_t;

  // Beat count of a burst; undefined-length bursts take the caller's length, with a length of zero giving one beat
  function automatic logic [LEN_W:0] beats_of(input logic [2:0] burst,
                                              input logic [LEN_W-1:0] len);
    logic [LEN_W:0] n;
    n = {1'b0, len};
    unique case (burst)
      BURST_SINGLE: n = BEATS_1;
      BURST_INCR: n = (len == '0) ? BEATS_1 : {1'b0, len};
      BURST_WRAP4, BURST_INCR4: n = BEATS_4;
      BURST_WRAP8, BURST_INCR8: n = BEATS_8;
      BURST_WRAP16, BURST_INCR16: n = BEATS_16;
    endcase
    return n;
  endfunction : beats_of

  function automatic logic is_wrap(input logic [2:0] burst);
    return (burst == BURST_WRAP4) || (burst == BURST_WRAP8) || (burst == BURST_WRAP16);
  endfunction : is_wrap

endpackage : ahbm_pkg

// file: hdl/ahbm_link_if.sv
// Interface joining the master core to its address stepper and response capture
`timescale 1ns/1ns
interface ahbm_link_if;
  logic [ahbm_pkg::ADDR_W-1:0] cur_addr;
  logic [ahbm_pkg::SIZE_W-1:0] size;
  logic [ahbm_pkg::BURST_W-1:0] burst;
  logic [ahbm_pkg::ADDR_W-1:0] next_addr;
  logic dp_act;
  logic dp_write;

  modport core (output cur_addr, output size, output burst, input next_addr,
                output dp_act, output dp_write);
  modport step (input cur_addr, input size, input burst, output next_addr);
  modport resp (input dp_act, input dp_write);
endinterface : ahbm_link_if

// file: hdl/ahbm_addr_step.sv
// Next-beat address: increment by transfer size, wrapping for wrap bursts
`timescale 1ns/1ns
module ahbm_addr_step (
  ahbm_link_if.step lnk
);
  logic [ahbm_pkg::ADDR_W-1:0] inc;
  logic [ahbm_pkg::ADDR_W-1:0] span;
  logic [ahbm_pkg::ADDR_W-1:0] mask;
  logic [ahbm_pkg::ADDR_W-1:0] sum;

  always_comb
  begin
    inc = ahbm_pkg::ADDR_W'(1) << lnk.size;
    // Wrap span is beats times bytes per beat; only used for wrap bursts
    span = ahbm_pkg::ADDR_W'(ahbm_pkg::beats_of(lnk.burst, '0)) << lnk.size;
    mask = span - ahbm_pkg::ADDR_W'(1);
    sum = lnk.cur_addr + inc; // R16
    if (ahbm_pkg::is_wrap(lnk.burst))
      lnk.next_addr = (lnk.cur_addr & ~mask) | (sum & mask); // R17
    else
      lnk.next_addr = sum;
  end
endmodule : ahbm_addr_step

// file: hdl/ahbm_resp_cap.sv
// Captures the slave's answer at the end of each data phase
`timescale 1ns/1ns
module ahbm_resp_cap (
  input wire logic core_clk,
  input wire logic rst,
  ahbm_link_if.resp lnk,
  input wire logic hready,
  input wire logic [1:0] hresp,
  input wire logic [ahbm_pkg::DATA_W-1:0] hrdata,
  output logic rsp_valid,
  output logic rsp_write,
  output logic [1:0] rsp_resp,
  output logic [ahbm_pkg::DATA_W-1:0] rsp_rdata
);
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] resp;
    logic [ahbm_pkg::DATA_W-1:0] rdata;
  } ahbm_rsp_t;

  ahbm_rsp_t q, d;

  always_comb
  begin
    d = q;
    d.valid = 1'b0;
    // Completion only in a cycle with ready high; waits before it carry junk
    if (lnk.dp_act && hready) // R18
    begin
      d.valid = 1'b1; // R4
      d.write = lnk.dp_write;
      d.resp = hresp; // R19
      if (!lnk.dp_write)
        d.rdata = hrdata; // R7
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign rsp_valid = q.valid;
  assign rsp_write = q.write;
  assign rsp_resp = q.resp;
  assign rsp_rdata = q.rdata;
endmodule : ahbm_resp_cap

// file: hdl/ahbm_master.sv
// Pipelined bus master: issues bursts, inserts BUSY, tracks the data phase
`timescale 1ns/1ns
module ahbm_master (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [ahbm_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [ahbm_pkg::SIZE_W-1:0] cmd_size,
  input wire logic [ahbm_pkg::BURST_W-1:0] cmd_burst,
  input wire logic [ahbm_pkg::LEN_W-1:0] cmd_len,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [ahbm_pkg::DATA_W-1:0] wr_data,
  output logic rsp_valid,
  output logic rsp_write,
  output logic [1:0] rsp_resp,
  output logic [ahbm_pkg::DATA_W-1:0] rsp_rdata,
  output logic busy,
  output logic [ahbm_pkg::ADDR_W-1:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [ahbm_pkg::SIZE_W-1:0] hsize,
  output logic [ahbm_pkg::BURST_W-1:0] hburst,
  output logic [ahbm_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  input wire logic [1:0] hresp,
  input wire logic [ahbm_pkg::DATA_W-1:0] hrdata
);
  typedef struct packed {
    ahbm_pkg::ahbm_state_t st;
    logic [1:0] htrans;
    logic [ahbm_pkg::ADDR_W-1:0] haddr;
    logic hwrite;
    logic [ahbm_pkg::SIZE_W-1:0] hsize;
    logic [ahbm_pkg::BURST_W-1:0] hburst;
    logic [ahbm_pkg::DATA_W-1:0] beat_wdata;
    logic [ahbm_pkg::ADDR_W-1:0] nxt_addr;
    logic [ahbm_pkg::LEN_W:0] left;
    logic first;
    logic dp_act;
    logic dp_write;
    logic [ahbm_pkg::DATA_W-1:0] hwdata;
  } ahbm_core_t;

  ahbm_core_t q, d;
  ahbm_link_if lnk ();
  logic abort;
  logic have_data;

  assign lnk.cur_addr = q.nxt_addr;
  assign lnk.size = q.hsize;
  assign lnk.burst = q.hburst;
  assign lnk.dp_act = q.dp_act;
  assign lnk.dp_write = q.dp_write;

  ahbm_addr_step u_step (
    .lnk(lnk.step)
  );

  ahbm_resp_cap u_resp (
    .core_clk(core_clk),
    .rst(rst),
    .lnk(lnk.resp),
    .hready(hready),
    .hresp(hresp),
    .hrdata(hrdata),
    .rsp_valid(rsp_valid),
    .rsp_write(rsp_write),
    .rsp_resp(rsp_resp),
    .rsp_rdata(rsp_rdata)
  );

  // Any non-OKAY answer ends the burst early; RETRY and SPLIT are not replayed
  assign abort = q.dp_act && (hresp != ahbm_pkg::RESP_OKAY);
  assign have_data = !q.hwrite || wr_valid;

  always_comb
  begin
    d = q;
    cmd_ready = 1'b0;
    wr_ready = 1'b0;
    // Nothing moves while ready is low: address, control and write data hold
    if (hready) // R8
    begin
      // The accepted address phase becomes the data phase of the next cycle
      d.dp_act = (q.htrans == ahbm_pkg::TR_NONSEQ) || (q.htrans == ahbm_pkg::TR_SEQ); // R5
      d.dp_write = q.hwrite;
      if (d.dp_act && q.hwrite)
        d.hwdata = q.beat_wdata; // R6
      unique case (q.st)
        ahbm_pkg::AHBM_IDLE_S:
        begin
          d.htrans = ahbm_pkg::TR_IDLE; // R10
          cmd_ready = 1'b1;
          if (cmd_valid)
          begin
            d.st = ahbm_pkg::AHBM_RUN_S;
            d.nxt_addr = cmd_addr;
            d.hwrite = cmd_write;
            d.hsize = cmd_size;
            d.hburst = cmd_burst;
            d.left = ahbm_pkg::beats_of(cmd_burst, cmd_len);
            d.first = 1'b1;
          end
        end
        ahbm_pkg::AHBM_RUN_S:
        begin
          if (abort || (q.left == '0))
          begin
            d.htrans = ahbm_pkg::TR_IDLE; // R9
            d.st = ahbm_pkg::AHBM_IDLE_S;
            d.left = '0;
          end
          else if (have_data)
          begin
            // One address phase per beat, changed only just after an edge
            d.htrans = q.first ? ahbm_pkg::TR_NONSEQ : ahbm_pkg::TR_SEQ; // R14 R15 R1 R3
            d.haddr = q.nxt_addr;
            d.nxt_addr = lnk.next_addr; // R16 R17
            d.beat_wdata = wr_data;
            d.left = q.left - ahbm_pkg::BEATS_1;
            d.first = 1'b0;
            wr_ready = q.hwrite;
          end
          else
          begin
            // Write data late: pause, already showing the coming beat
            d.htrans = q.first ? ahbm_pkg::TR_IDLE : ahbm_pkg::TR_BUSY; // R12
            d.haddr = q.nxt_addr;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      q <= '0;
      q.st <= ahbm_pkg::AHBM_IDLE_S;
      q.htrans <= ahbm_pkg::TR_IDLE; // R21
    end
    else
      q <= d;
  end

  assign haddr = q.haddr;
  assign htrans = q.htrans;
  assign hwrite = q.hwrite;
  assign hsize = q.hsize;
  assign hburst = q.hburst;
  assign hwdata = q.hwdata;
  assign busy = (q.st != ahbm_pkg::AHBM_IDLE_S) || q.dp_act;
endmodule : ahbm_master

// file: hdl/ahbm_addr_step_fix_note.sv
// Spare source slot; all logic lives in the three design modules

// file: dv/ahbm_slave_model.sv
// Behavioural bus slave with wait states and error answers
`timescale 1ns/1ns
module ahbm_slave_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [3:0] n_wait,
  input wire logic err,
  output logic hready,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  output logic [31:0] wr_seen
);
  logic act_q, wr_q;
  logic [31:0] a_q;
  logic [3:0] cnt_q;
  assign hready = !act_q || cnt_q == 4'h0;
  // Two-cycle error answer, so err needs n_wait of one or more
  assign hresp = (act_q && err && cnt_q < 4'h2) ? 2'h1 : 2'h0;
  // Junk in wait cycles so early sampling is caught
  assign hrdata = hready ? a_q ^ 32'h5a5a0000 : ~a_q;
  always @(posedge core_clk)
  begin
    if (rst)
      act_q <= 1'b0;
    else if (!hready)
      cnt_q <= cnt_q - 4'h1;
    else
    begin
      if (act_q && wr_q)
        wr_seen <= hwdata;
      act_q <= htrans[1];
      a_q <= haddr;
      wr_q <= hwrite;
      cnt_q <= n_wait;
    end
  end
endmodule : ahbm_slave_model

// file: dv/ahbm_master_sva.sv
// Checker for the master's bus-side timing
`timescale 1ns/1ns
module ahbm_master_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rsp_valid,
  input wire logic [1:0] rsp_resp,
  input wire logic [31:0] rsp_rdata,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [2:0] hburst,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [1:0] hresp,
  input wire logic [31:0] hrdata
);
  logic dp_q, dw_q;
  logic [31:0] la_q, msk;
  logic [6:0] lc_q;
  wire done = dp_q && hready;
  wire seq = htrans == 2'h3;
  assign msk = ((32'h2 << hburst[2:1]) << hsize) - 32'h1;
  always_ff @(posedge core_clk)
  begin
    if (rst)
      dp_q <= 1'b0;
    else if (hready)
    begin
      dp_q <= htrans[1];
      dw_q <= htrans[1] && hwrite;
      if (htrans[1])
        la_q <= haddr;
      if (htrans[1])
        lc_q <= {hwrite, hsize, hburst};
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  addr_hold_a: assert property (!hready |=> $stable({haddr, htrans, hwrite, hsize, hburst}))
    else $error("address moved in wait");
  wdata_hold_a: assert property (dw_q && !hready |=> $stable(hwdata))
    else $error("write data moved in wait");
  incr_step_a: assert property (seq && hburst[0] |-> haddr == la_q + (32'h1 << hsize))
    else $error("bad incrementing step");
  wrap_step_a: assert property (seq && !hburst[0] |-> haddr ==
    (la_q & ~msk | (la_q + (32'h1 << hsize)) & msk)) else $error("bad wrapping step");
  ctrl_same_a: assert property (seq |-> {hwrite, hsize, hburst} == lc_q)
    else $error("control changed in burst");
  reset_idle_a: assert property ($fell(rst) |-> htrans == 2'h0)
    else $error("not idle after reset");
  rsp_time_a: assert property (done |=> rsp_valid && rsp_resp == $past(hresp))
    else $error("answer not reported");
  rsp_none_a: assert property (!done |=> !rsp_valid)
    else $error("answer without transfer");
  rdata_take_a: assert property (done && !dw_q |=> rsp_rdata == $past(hrdata))
    else $error("read data wrong");
  err_stop_a: assert property (done && hresp != 2'h0 |=> htrans == 2'h0)
    else $error("burst not dropped");
  burst_pipe_a: assert property (hready && htrans == 2'h2 && !hwrite && hburst > 3'h1 |=> seq)
    else $error("no overlapped beat");
  cover property (dw_q && !hready);
  cover property (htrans == 2'h1);
  cover property (done && hresp == 2'h1);
endmodule : ahbm_master_sva
bind ahbm_master ahbm_master_sva u_sva (
  .core_clk(core_clk),
  .rst(rst),
  .rsp_valid(rsp_valid),
  .rsp_resp(rsp_resp),
  .rsp_rdata(rsp_rdata),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hsize(hsize),
  .hburst(hburst),
  .hwdata(hwdata),
  .hready(hready),
  .hresp(hresp),
  .hrdata(hrdata)
);

// file: dv/testbench.sv
// Self-checking bench for the pipelined bus master
`timescale 1ns/1ns
module testbench;
  logic core_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_write = 1'b0, wr_valid = 1'b0;
  logic err = 1'b0, cmd_ready, wr_ready, rsp_valid, rsp_write, busy, hwrite, hready;
  logic [31:0] cmd_addr = 32'h0, wr_data = 32'h0, rsp_rdata, haddr, hwdata, hrdata, wr_seen, l_rd;
  logic [2:0] cmd_size = 3'h0, cmd_burst = 3'h0, hsize, hburst;
  logic [7:0] cmd_len = 8'h0;
  logic [3:0] n_wait = 4'h0;
  logic [1:0] rsp_resp, htrans, hresp, l_rsp;
  logic tk = 1'b0, l_wr;
  int n_mismatch = 0, checks = 0, n_rsp = 0;
  ahbm_master u_dut (.*);
  ahbm_slave_model u_slave (.*);
  always #25 core_clk = ~core_clk;
  // Outputs are looked at mid-cycle, where they have settled
  always @(negedge core_clk)
  begin
    tk <= (wr_valid === 1'b1) && (wr_ready === 1'b1);
    if (rsp_valid === 1'b1)
    begin
      n_rsp <= n_rsp + 1;
      l_rsp <= rsp_resp;
      l_rd <= rsp_rdata;
      l_wr <= rsp_write;
    end
  end
  always @(posedge core_clk)
  begin
    #1;
    if (tk)
      wr_data = wr_data + 32'h1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic run(input logic w, input logic [31:0] a, input logic [2:0] s,
                     input logic [2:0] b, input int n);
    int i;
    i = 0;
    {cmd_write, cmd_addr, cmd_size, cmd_burst} = {w, a, s, b};
    cmd_valid = 1'b1;
    n_rsp = 0;
    while (cmd_ready !== 1'b1 && i < 300)
    begin
      tick(1);
      i++;
    end
    tick(1);
    cmd_valid = 1'b0;
    chk({31'h0, busy}, 32'h1);
    while (n_rsp < n && i < 300)
    begin
      tick(1);
      i++;
    end
    if (i >= 300)
    begin
      n_mismatch++;
      $display("unexpected at %0t: no response", $time);
      close_out();
    end
    tick(6);
    chk({31'h0, busy}, 32'h0);
  endtask : run
  task automatic t_incr4();
    run(1'b0, 32'h100, 3'h2, ahbm_pkg::BURST_INCR4, 4);
    chk(32'(n_rsp), 32'h4);
    chk(l_rd, 32'h5a5a010c);
    chk({31'h0, l_wr}, 32'h0);
  endtask : t_incr4
  task automatic t_wrap8();
    n_wait = 4'h2;
    run(1'b0, 32'h3c, 3'h1, ahbm_pkg::BURST_WRAP8, 8);
    chk(l_rd, 32'h5a5a003a);
  endtask : t_wrap8
  task automatic t_write_busy();
    int i;
    n_wait = 4'h1;
    wr_data = 32'h0;
    wr_valid = 1'b1;
    fork
      run(1'b1, 32'h200, 3'h2, ahbm_pkg::BURST_INCR4, 4);
      begin
        for (i = 0; i < 20 && wr_ready !== 1'b1; i++) tick(1);
        if (i >= 20)
        begin
          n_mismatch++;
          $display("unexpected at %0t: write data never taken", $time);
          close_out();
        end
        tick(1);
        wr_valid = 1'b0;
        tick(4);
        wr_valid = 1'b1;
      end
    join
    chk(wr_seen, 32'h3);
    chk({30'h0, l_rsp}, 32'h0);
    chk({31'h0, l_wr}, 32'h1);
    wr_valid = 1'b0;
  endtask : t_write_busy
  task automatic t_error();
    n_wait = 4'h1;
    err = 1'b1;
    run(1'b0, 32'h400, 3'h2, ahbm_pkg::BURST_INCR8, 2);
    tick(10);
    chk(32'(n_rsp), 32'h2);
    chk({30'h0, l_rsp}, {30'h0, ahbm_pkg::RESP_ERROR});
    err = 1'b0;
  endtask : t_error
  task automatic rd_burst(input logic [31:0] a, input logic [2:0] s, input logic [2:0] b,
                          input int n, input logic [31:0] last);
    run(1'b0, a, s, b, n);
    chk(32'(n_rsp), 32'(n));
    chk(l_rd, last);
    chk({30'h0, l_rsp}, {30'h0, ahbm_pkg::RESP_OKAY});
    chk({31'h0, l_wr}, 32'h0);
  endtask : rd_burst
  task automatic t_burst_codes();
    // Undefined length takes its beat count from the command
    cmd_len = 8'h3;
    rd_burst(32'h5c, 3'h2, ahbm_pkg::BURST_INCR, 3, 32'h5a5a0064);
    cmd_len = 8'h0;
    rd_burst(32'h34, 3'h2, ahbm_pkg::BURST_WRAP4, 4, 32'h5a5a0030);
    rd_burst(32'h80, 3'h0, ahbm_pkg::BURST_INCR16, 16, 32'h5a5a008f);
    rd_burst(32'h44, 3'h2, ahbm_pkg::BURST_WRAP16, 16, 32'h5a5a0040);
  endtask : t_burst_codes
  task automatic t_single_wr();
    wr_data = 32'h77;
    wr_valid = 1'b1;
    run(1'b1, 32'h21, 3'h0, ahbm_pkg::BURST_SINGLE, 1);
    wr_valid = 1'b0;
    chk(32'(n_rsp), 32'h1);
    chk(wr_seen, 32'h77);
    chk({31'h0, l_wr}, 32'h1);
  endtask : t_single_wr
  initial
  begin
    tick(2);
    rst = 1'b0;
    tick(1);
    chk({30'h0, htrans}, {30'h0, ahbm_pkg::TR_IDLE});
    t_incr4();
    t_wrap8();
    t_write_busy();
    t_error();
    t_burst_codes();
    t_single_wr();
    close_out();
  end
endmodule : testbench
